// >>> src/ueh_pkg.sv
// ueh_pkg: constants, types and carriers for the endpoint handshake controller.
// assumes registers are reached over apb at byte address = 4 * register index.
package ueh_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices (byte address is four times the index)
    localparam logic [7:0] IDX_DEV_ADDR = 8'hcc;
    localparam logic [7:0] IDX_STATUS = 8'hcd;
    localparam logic [7:0] IDX_ACK_FLAGS = 8'hd0;
    localparam logic [7:0] IDX_DIR = 8'hd3;
    localparam logic [7:0] IDX_FIFO_DATA = 8'hf0;
    // ep0 .. ep5 control and byte count, ep0 in the low byte
    localparam logic [5:0][7:0] IDX_EP_CTL = {8'hdf, 8'hdd, 8'hdb, 8'hd9, 8'hd7, 8'hd5};
    localparam logic [5:0][7:0] IDX_EP_CNT = {8'he0, 8'hde, 8'hdc, 8'hda, 8'hd8, 8'hd6};

    localparam int unsigned NUM_EP = 6;
    localparam logic [3:0] EP_LIMIT = 4'h6;
    localparam int unsigned PADDR_W = 10;

    ////////////////////////////////////////////////////////////////////////////
    // field positions, masks, reset values
    localparam int unsigned B_EN = 7;
    localparam int unsigned B_MODE_HI = 6;
    localparam int unsigned B_MODE_LO = 5;
    localparam int unsigned B_OUT_STALL = 4;
    localparam int unsigned B_IN_STALL = 3;
    localparam int unsigned B_DEV_EN = 7;
    localparam int unsigned B_DONE_A = 4;
    localparam int unsigned B_DONE_B = 3;
    localparam logic [7:0] CTL0_MASK = 8'hf8;
    localparam logic [7:0] CTLN_MASK = 8'he0;
    localparam logic [7:0] CNT0_MASK = 8'h7f;
    localparam logic [7:0] CNTN_MASK = 8'hff;
    localparam logic [7:0] STATUS_MASK = 8'h18;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] RESP_NAK = 2'h0;
    localparam logic [1:0] RESP_ACK = 2'h1;

    localparam int unsigned FIFO_W = 8;
    localparam int unsigned FIFO_DEPTH = 16;

    ////////////////////////////////////////////////////////////////////////////
    // enumerations and carriers
    typedef enum logic [1:0] {
        TOK_OUT = 2'h0,
        TOK_IN = 2'h1,
        TOK_SETUP = 2'h2
    } ueh_tok_kind_t;

    typedef enum logic [1:0] {
        HS_ACK = 2'h0,
        HS_NAK = 2'h1,
        HS_STALL = 2'h2
    } ueh_hs_code_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_WAIT = 3'b100
    } ueh_state_t;

    typedef struct packed {
        logic valid;
        ueh_tok_kind_t kind;
        logic [6:0] addr;
        logic [3:0] ep;
    } ueh_token_t;

    typedef struct packed {
        logic valid;
        ueh_hs_code_t code;
    } ueh_hs_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ueh_tx_t;

endpackage : ueh_pkg

// >>> src/ueh_endpoint_ctrl.sv
// ueh_endpoint_ctrl: endpoint handshake control with apb registers and a tx byte fifo.
// assumes the serial engine decodes tokens into one-cycle pulses synchronous to mclk.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// byte fifo, depth and width shape the storage
module ueh_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned DEPTH = 16
) (
    input wire logic mclk, // clock
    input wire logic rstn, // sync reset, active low
    input wire logic ce, // clock enable
    input wire logic in_valid, // push request
    output logic in_ready, // room for a word
    input wire logic [W-1:0] in_data, // pushed word
    output logic out_valid, // word available
    input wire logic out_ready, // pop request
    output logic [W-1:0] out_data // head word
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] wr;
        logic [AW:0] rd;
    } ueh_fifo_st_t;
    ueh_fifo_st_t q, d;

    // pointers carry an extra wrap bit so full and empty stay distinct
    assign out_valid = q.wr != q.rd;
    assign in_ready = q.wr != {~q.rd[AW], q.rd[AW-1:0]};
    assign out_data = q.mem[q.rd[AW-1:0]];

    // push and pop
    always_comb begin
        d = q;
        if (in_valid && in_ready) begin
            d.mem[q.wr[AW-1:0]] = in_data;
            d.wr = q.wr + 1'b1;
        end
        if (out_valid && out_ready) begin
            d.rd = q.rd + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule : ueh_fifo

////////////////////////////////////////////////////////////////////////////////
module ueh_endpoint_ctrl (
    input wire logic mclk, // 50 mhz clock
    input wire logic rstn, // sync reset, active low
    input wire logic ce, // clock enable, freezes all state
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [ueh_pkg::PADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input ueh_pkg::ueh_token_t tok_i, // decoded token pulse
    input wire logic host_ack_i, // host acked the in data packet
    output ueh_pkg::ueh_hs_t hs_o, // handshake request pulse
    output ueh_pkg::ueh_tx_t tx_o, // in data byte stream
    input wire logic tx_ready_i // serial engine takes the byte
);
    typedef struct packed {
        ueh_pkg::ueh_state_t state;
        logic [5:0][7:0] ctl;
        logic [5:0][7:0] cnt;
        logic [7:0] dev;
        logic [7:0] stat;
        logic [5:1] ack;
        logic [5:1] dir;
        logic [2:0] cur_ep;
        logic [7:0] rem;
        ueh_pkg::ueh_hs_t hs;
        ueh_pkg::ueh_tx_t tx;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } ueh_st_t;

    ueh_st_t q, d;
    logic fifo_push, fifo_in_ready, fifo_out_valid, fifo_pop;
    logic [7:0] fifo_data;
    logic addr_ok, resp_ok, dir_ok;
    logic [2:0] epi;
    logic [7:0] want_cnt;

    // maps a two-bit response mode onto a handshake
    function automatic ueh_pkg::ueh_hs_code_t mode_hs(input logic [1:0] m);
        if (m == ueh_pkg::RESP_NAK) begin
            return ueh_pkg::HS_NAK;
        end else if (m == ueh_pkg::RESP_ACK) begin
            return ueh_pkg::HS_ACK;
        end
        return ueh_pkg::HS_STALL;
    endfunction : mode_hs

    // writable bits of control or count register of an endpoint
    function automatic logic [7:0] ep_mask(input int unsigned i, input logic is_ctl);
        if (is_ctl) begin
            return (i == 0) ? ueh_pkg::CTL0_MASK : ueh_pkg::CTLN_MASK;
        end
        return (i == 0) ? ueh_pkg::CNT0_MASK : ueh_pkg::CNTN_MASK;
    endfunction : ep_mask

    ueh_fifo #(.W(ueh_pkg::FIFO_W), .DEPTH(ueh_pkg::FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rstn(rstn),
        .ce(ce),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(pwdata[7:0]),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // token qualification shared by the sequencer and the checks
    assign epi = tok_i.ep[2:0];
    assign addr_ok = q.dev[ueh_pkg::B_DEV_EN] && (tok_i.addr == q.dev[6:0]);
    assign resp_ok = addr_ok && (tok_i.ep < ueh_pkg::EP_LIMIT) && q.ctl[epi][ueh_pkg::B_EN];
    // ep1-5 answer only their selected direction
    assign dir_ok = (epi == 3'h0) ||
                    ((tok_i.kind == ueh_pkg::TOK_IN) && !q.dir[epi]) ||
                    ((tok_i.kind == ueh_pkg::TOK_OUT) && q.dir[epi]);
    assign want_cnt = q.cnt[epi] & ep_mask(32'(epi), 1'b0);

    ////////////////////////////////////////////////////////////////////////////
    // next state: bus access first, hardware events after so their sets win
    always_comb begin
        logic acc, wr_fire, hit, to_fifo;
        logic [7:0] idx, rd;
        ueh_pkg::ueh_hs_code_t code;
        acc = psel && penable;
        wr_fire = acc && q.pready && pwrite;
        idx = paddr[ueh_pkg::PADDR_W-1:2];
        hit = 1'b1;
        rd = ueh_pkg::REG_RESET;
        code = ueh_pkg::HS_NAK;
        d = q;
        d.hs.valid = 1'b0;
        fifo_push = 1'b0;
        fifo_pop = 1'b0;
        to_fifo = idx == ueh_pkg::IDX_FIFO_DATA;

        // register decode, read value and software writes
        unique case (idx)
            ueh_pkg::IDX_DEV_ADDR: rd = q.dev;
            ueh_pkg::IDX_STATUS: rd = q.stat;
            ueh_pkg::IDX_ACK_FLAGS: rd = {3'h0, q.ack};
            ueh_pkg::IDX_DIR: rd = {3'h0, q.dir};
            ueh_pkg::IDX_FIFO_DATA: rd = ueh_pkg::REG_RESET;
            default: hit = 1'b0;
        endcase
        for (int i = 0; i < ueh_pkg::NUM_EP; i++) begin
            if (idx == ueh_pkg::IDX_EP_CTL[i]) begin
                rd = q.ctl[i];
                hit = 1'b1;
                if (wr_fire) begin
                    d.ctl[i] = pwdata[7:0] & ep_mask(i, 1'b1);
                end
            end
            if (idx == ueh_pkg::IDX_EP_CNT[i]) begin
                rd = q.cnt[i];
                hit = 1'b1;
                if (wr_fire) begin
                    // firmware loads the in byte count
                    d.cnt[i] = pwdata[7:0] & ep_mask(i, 1'b0);
                end
            end
        end
        if (wr_fire) begin
            unique case (idx)
                ueh_pkg::IDX_DEV_ADDR: d.dev = pwdata[7:0];
                ueh_pkg::IDX_STATUS: d.stat = q.stat & pwdata[7:0] & ueh_pkg::STATUS_MASK;
                ueh_pkg::IDX_ACK_FLAGS: d.ack = q.ack & pwdata[4:0];
                ueh_pkg::IDX_DIR: d.dir = pwdata[4:0];
                ueh_pkg::IDX_FIFO_DATA: fifo_push = 1'b1;
                default: d.dev = q.dev;
            endcase
        end

        // one wait state; a full fifo holds pready low to push back on firmware
        if (acc && !q.pready) begin
            if (!(pwrite && to_fifo && !fifo_in_ready)) begin
                d.pready = 1'b1;
                d.prdata = {24'h0, rd};
                d.pslverr = !hit;
            end
        end else begin
            d.pready = 1'b0;
            d.pslverr = 1'b0;
        end

        // transaction sequencer
        unique case (q.state)
            ueh_pkg::ST_IDLE: begin
                if (tok_i.valid && resp_ok && dir_ok) begin
                    if (epi == 3'h0) begin
                        if (tok_i.kind == ueh_pkg::TOK_SETUP) begin
                            d.ctl[0][ueh_pkg::B_OUT_STALL] = 1'b0;
                            d.ctl[0][ueh_pkg::B_IN_STALL] = 1'b0;
                            code = ueh_pkg::HS_ACK;
                        end else if (tok_i.kind == ueh_pkg::TOK_OUT &&
                                     q.ctl[0][ueh_pkg::B_OUT_STALL]) begin
                            code = ueh_pkg::HS_STALL;
                        end else if (tok_i.kind == ueh_pkg::TOK_IN &&
                                     q.ctl[0][ueh_pkg::B_IN_STALL]) begin
                            code = ueh_pkg::HS_STALL;
                        end else begin
                            code = mode_hs(q.ctl[0][ueh_pkg::B_MODE_HI:ueh_pkg::B_MODE_LO]);
                        end
                    end else begin
                        // same table on ep1-5, 00 naks
                        code = mode_hs(q.ctl[epi][ueh_pkg::B_MODE_HI:ueh_pkg::B_MODE_LO]);
                    end
                    d.cur_ep = epi;
                    if (epi != 3'h0 && tok_i.kind == ueh_pkg::TOK_SETUP) begin
                        // setup only belongs to the control pipe
                        d.cur_ep = q.cur_ep;
                    end else if (code == ueh_pkg::HS_ACK && tok_i.kind == ueh_pkg::TOK_IN) begin
                        // in data goes out first, the host acks afterwards
                        d.state = ueh_pkg::ST_SEND;
                        d.rem = want_cnt;
                    end else begin
                        d.hs.valid = 1'b1;
                        d.hs.code = code;
                        if (code == ueh_pkg::HS_ACK && tok_i.kind == ueh_pkg::TOK_OUT) begin
                            // out ack completes, fall back to nak
                            d.ctl[epi][ueh_pkg::B_MODE_LO] = 1'b0;
                            if (epi != 3'h0) begin
                                d.ack[epi] = 1'b1;
                            end
                        end
                        if (code == ueh_pkg::HS_STALL && epi == 3'h0) begin
                            if (tok_i.kind == ueh_pkg::TOK_OUT) begin
                                d.stat[ueh_pkg::B_DONE_A] = 1'b1;
                            end else begin
                                d.stat[ueh_pkg::B_DONE_B] = 1'b1;
                            end
                        end
                    end
                end
            end
            ueh_pkg::ST_SEND: begin
                if (q.tx.valid && tx_ready_i) begin
                    d.tx.valid = 1'b0;
                end
                if (!q.tx.valid || tx_ready_i) begin
                    if (q.rem != 8'h00) begin
                        if (fifo_out_valid) begin
                            fifo_pop = 1'b1;
                            d.tx.valid = 1'b1;
                            d.tx.data = fifo_data;
                            d.rem = q.rem - 8'h01;
                        end
                    end else begin
                        d.state = ueh_pkg::ST_WAIT;
                    end
                end
            end
            ueh_pkg::ST_WAIT: begin
                if (host_ack_i) begin
                    // in ack completes, fall back to nak
                    d.ctl[q.cur_ep][ueh_pkg::B_MODE_LO] = 1'b0;
                    if (q.cur_ep != 3'h0) begin
                        d.ack[q.cur_ep] = 1'b1;
                    end
                    d.state = ueh_pkg::ST_IDLE;
                end else if (tok_i.valid) begin
                    // host gave up; mode stays so a retry is answered again
                    d.state = ueh_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            q <= '0;
            q.state <= ueh_pkg::ST_IDLE;
        end else if (ce) begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign hs_o = q.hs;
    assign tx_o = q.tx;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence idle_tok_s;
        ce && q.state == ueh_pkg::ST_IDLE && tok_i.valid;
    endsequence
    sequence ep0_live_s;
        idle_tok_s ##0 (resp_ok && epi == 3'h0);
    endsequence

    ep0_disabled_a: assert property (
        idle_tok_s ##0 (tok_i.ep == 4'h0 && !q.ctl[0][ueh_pkg::B_EN])
        |=> !hs_o.valid && q.state == ueh_pkg::ST_IDLE)
        else $error("disabled ep0 answered");
    mode_nak_a: assert property (
        idle_tok_s ##0 (resp_ok && dir_ok && epi != 3'h0 && tok_i.kind != ueh_pkg::TOK_SETUP &&
        q.ctl[epi][ueh_pkg::B_MODE_HI:ueh_pkg::B_MODE_LO] == ueh_pkg::RESP_NAK)
        |=> hs_o.valid && hs_o.code == ueh_pkg::HS_NAK)
        else $error("mode 00 did not nak");
    ack_clear_a: assert property (
        ce && q.state == ueh_pkg::ST_WAIT && host_ack_i
        |=> !q.ctl[q.cur_ep][ueh_pkg::B_MODE_LO] && q.state == ueh_pkg::ST_IDLE)
        else $error("mode low bit not cleared after ack");
    out_stall_a: assert property (
        ep0_live_s ##0 (tok_i.kind == ueh_pkg::TOK_OUT && q.ctl[0][ueh_pkg::B_OUT_STALL])
        |=> hs_o.valid && hs_o.code == ueh_pkg::HS_STALL && q.stat[ueh_pkg::B_DONE_A])
        else $error("out override did not stall");
    in_stall_a: assert property (
        ep0_live_s ##0 (tok_i.kind == ueh_pkg::TOK_IN && q.ctl[0][ueh_pkg::B_IN_STALL])
        |=> hs_o.valid && hs_o.code == ueh_pkg::HS_STALL && q.stat[ueh_pkg::B_DONE_B])
        else $error("in override did not stall");
    setup_clear_a: assert property (
        ep0_live_s ##0 (tok_i.kind == ueh_pkg::TOK_SETUP)
        |=> q.ctl[0][ueh_pkg::B_OUT_STALL:ueh_pkg::B_IN_STALL] == 2'h0)
        else $error("setup left a stall override set");
    send_count_a: assert property (
        idle_tok_s ##0 (resp_ok && dir_ok && tok_i.kind == ueh_pkg::TOK_IN &&
        !(epi == 3'h0 && q.ctl[0][ueh_pkg::B_IN_STALL]) &&
        q.ctl[epi][ueh_pkg::B_MODE_HI:ueh_pkg::B_MODE_LO] == ueh_pkg::RESP_ACK)
        |=> q.state == ueh_pkg::ST_SEND && q.rem == $past(want_cnt) && !hs_o.valid)
        else $error("in ack did not load the byte count");
    dir_gate_a: assert property (
        idle_tok_s ##0 (epi != 3'h0 && !dir_ok) |=> !hs_o.valid && q.state == ueh_pkg::ST_IDLE)
        else $error("wrong direction answered");
    addr_gate_a: assert property (
        idle_tok_s ##0 !addr_ok |=> !hs_o.valid && q.state == ueh_pkg::ST_IDLE)
        else $error("answered foreign address");
    ack_flag_a: assert property (
        ce && q.state == ueh_pkg::ST_WAIT && host_ack_i && q.cur_ep != 3'h0
        |=> q.ack[q.cur_ep])
        else $error("ack flag not set");
endmodule : ueh_endpoint_ctrl

// >>> sim/ueh_host_model.sv
// ueh_host_model: host and serial engine stand-in on the token side of the block.
// assumes it shares mclk with the block; tokens are one-cycle pulses.
`timescale 1ns/1ns
module ueh_host_model (
    input wire logic mclk, // clock
    output ueh_pkg::ueh_token_t tok, // token pulse to the block
    output logic ack, // host took the in data packet
    output logic rdy, // byte sink ready
    input ueh_pkg::ueh_hs_t hs, // handshake pulse from the block
    input ueh_pkg::ueh_tx_t tx // in data byte from the block
);
    logic slow = 1'b0; // sink stalls two cycles in three
    logic [1:0] ph = 2'h0;
    logic seen = 1'b0;
    logic [1:0] code = 2'h0;
    logic [7:0] rxq[$];
    initial begin
        tok = '0;
        ack = 1'b0;
        rdy = 1'b1;
    end
    ////////////////////////////////////////
    // sink keeps every byte taken
    always @(posedge mclk) begin
        ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        rdy <= !slow || ph == 2'h2;
        if (tx.valid === 1'b1 && rdy) begin
            rxq.push_back(tx.data);
        end
    end
    // handshake watch, mid-cycle so values have settled
    always @(negedge mclk) begin
        if (hs.valid === 1'b1) begin
            seen <= 1'b1;
            code <= hs.code;
        end
    end
    // token pulse; released fields flip so stale values cannot match
    task automatic send(input ueh_pkg::ueh_tok_kind_t k, input logic [6:0] a,
                        input logic [3:0] ep);
        seen = 1'b0;
        @(posedge mclk);
        tok <= '{1'b1, k, a, ep};
        @(posedge mclk);
        tok <= '{1'b0, ueh_pkg::TOK_SETUP, ~a, ~ep};
        repeat (4) @(posedge mclk);
    endtask : send
    // host acknowledge pulse after the data packet
    task automatic give_ack();
        @(posedge mclk);
        ack <= 1'b1;
        @(posedge mclk);
        ack <= 1'b0;
        @(posedge mclk);
    endtask : give_ack
endmodule : ueh_host_model

// >>> sim/testbench.sv
// testbench: register, token and in data scenarios for the endpoint controller.
// assumes ueh_pkg and the host model are compiled first.
`timescale 1ns/1ns
module testbench;
    localparam logic [6:0] DEV = 7'h2a; // device address of our choosing
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ueh_pkg::PADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ueh_pkg::ueh_token_t tok;
    logic host_ack;
    ueh_pkg::ueh_hs_t hs;
    ueh_pkg::ueh_tx_t tx;
    logic tx_ready;
    int err_total = 0;
    int comparisons = 0;
    ////////////////////////////////////////
    ueh_endpoint_ctrl ueh_endpoint_ctrl_i (.mclk(mclk), .rstn(rstn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tok_i(tok), .host_ack_i(host_ack), .hs_o(hs),
        .tx_o(tx), .tx_ready_i(tx_ready));
    ueh_host_model ueh_host_model_i (.mclk(mclk), .tok(tok), .ack(host_ack), .rdy(tx_ready),
        .hs(hs), .tx(tx));
    initial begin
        forever #10 mclk = ~mclk;
    end
    ////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic close_out();
        $display("counts: comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    // apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 300);
        rd = prdata;
        er = pslverr;
        if (n >= 300) cmp(32'h0, 32'h1, "apb wait ran out");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask : wr
    task automatic chk(input logic [7:0] idx, input logic [7:0] exp, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
        cmp(r, {24'h0, exp}, "read data");
        cmp({31'h0, e}, {31'h0, exp_err}, "slave error");
    endtask : chk
    // one token, then whether and how the block answered
    task automatic hsk(input ueh_pkg::ueh_tok_kind_t k, input logic [6:0] a, input int ep,
                       input logic on, input ueh_pkg::ueh_hs_code_t c);
        ueh_host_model_i.send(k, a, 4'(ep));
        cmp({31'h0, ueh_host_model_i.seen}, {31'h0, on}, "handshake given");
        if (on) cmp({30'h0, ueh_host_model_i.code}, {30'h0, c}, "handshake code");
    endtask : hsk
    function automatic ueh_pkg::ueh_hs_code_t want(input int m);
        return (m == 0) ? ueh_pkg::HS_NAK : (m == 1) ? ueh_pkg::HS_ACK : ueh_pkg::HS_STALL;
    endfunction : want
    task automatic fill(input int n);
        for (int i = 0; i < n; i++) begin
            wr(ueh_pkg::IDX_FIFO_DATA, 8'h40 + 8'(i));
        end
    endtask : fill
    // in token, collect n bytes, acknowledge, compare the stream
    task automatic drain(input int ep, input int n);
        int k;
        k = 0;
        ueh_host_model_i.rxq.delete();
        ueh_host_model_i.send(ueh_pkg::TOK_IN, DEV, 4'(ep));
        while (ueh_host_model_i.rxq.size() < n && k < 500) begin
            @(posedge mclk);
            k++;
        end
        ueh_host_model_i.give_ack();
        cmp(32'(ueh_host_model_i.rxq.size()), 32'(n), "byte count");
        for (int i = 0; i < n; i++) begin
            cmp({24'h0, ueh_host_model_i.rxq[i]}, 32'h40 + 32'(i), "byte value");
        end
    endtask : drain
    ////////////////////////////////////////
    task automatic t_regs();
        for (int i = 0; i < 6; i++) begin
            chk(ueh_pkg::IDX_EP_CTL[i], 8'h00, 1'b0); // control reset value
            chk(ueh_pkg::IDX_EP_CNT[i], 8'h00, 1'b0); // count reset value
        end
        wr(ueh_pkg::IDX_EP_CTL[0], 8'hff);
        chk(ueh_pkg::IDX_EP_CTL[0], 8'hf8, 1'b0); // ep0 control fields
        wr(ueh_pkg::IDX_EP_CNT[0], 8'hff);
        chk(ueh_pkg::IDX_EP_CNT[0], 8'h7f, 1'b0); // seven-bit count
        wr(ueh_pkg::IDX_EP_CTL[4], 8'hff);
        chk(ueh_pkg::IDX_EP_CTL[4], 8'he0, 1'b0); // upper three bits only
        wr(ueh_pkg::IDX_EP_CNT[5], 8'hff);
        chk(ueh_pkg::IDX_EP_CNT[5], 8'hff, 1'b0); // eight-bit count
        wr(8'h10, 8'h55);
        chk(8'h10, 8'h00, 1'b1);
        wr(ueh_pkg::IDX_EP_CTL[0], 8'h00);
        wr(ueh_pkg::IDX_EP_CTL[4], 8'h00);
        $display("test regs done, mismatches %0d", err_total);
    endtask : t_regs
    task automatic t_modes();
        logic [1:0] kept;
        wr(ueh_pkg::IDX_DEV_ADDR, {1'b1, DEV});
        wr(ueh_pkg::IDX_DIR, 8'h1f);
        for (int ep = 0; ep < 6; ep++) begin
            for (int m = 0; m < 4; m++) begin
                kept = (m == 1) ? 2'h0 : 2'(m);
                wr(ueh_pkg::IDX_EP_CTL[ep], {1'b1, 2'(m), 5'h00});
                hsk(ueh_pkg::TOK_OUT, DEV, ep, 1'b1, want(m)); // table
                chk(ueh_pkg::IDX_EP_CTL[ep], {1'b1, kept, 5'h00}, 1'b0); // low bit
            end
            hsk(ueh_pkg::TOK_OUT, 7'h11, ep, 1'b0, ueh_pkg::HS_ACK); // other address
            wr(ueh_pkg::IDX_EP_CTL[ep], 8'h20);
            hsk(ueh_pkg::TOK_OUT, DEV, ep, 1'b0, ueh_pkg::HS_ACK); // disabled
        end
        chk(ueh_pkg::IDX_ACK_FLAGS, 8'h1f, 1'b0); // flags of ep1 to ep5
        wr(ueh_pkg::IDX_ACK_FLAGS, 8'h00);
        wr(ueh_pkg::IDX_EP_CTL[2], 8'hc0);
        hsk(ueh_pkg::TOK_IN, DEV, 2, 1'b0, ueh_pkg::HS_STALL); // wrong direction
        wr(ueh_pkg::IDX_DIR, 8'h00);
        hsk(ueh_pkg::TOK_IN, DEV, 2, 1'b1, ueh_pkg::HS_STALL); // in direction
        hsk(ueh_pkg::TOK_OUT, DEV, 2, 1'b0, ueh_pkg::HS_STALL); // out now silent
        $display("test modes done, mismatches %0d", err_total);
    endtask : t_modes
    task automatic t_stall();
        wr(ueh_pkg::IDX_STATUS, 8'h00);
        wr(ueh_pkg::IDX_EP_CTL[0], 8'h90);
        hsk(ueh_pkg::TOK_OUT, DEV, 0, 1'b1, ueh_pkg::HS_STALL); // out stalled
        hsk(ueh_pkg::TOK_IN, DEV, 0, 1'b1, ueh_pkg::HS_NAK); // in keeps mode
        chk(ueh_pkg::IDX_STATUS, 8'h10, 1'b0); // out stall flag
        wr(ueh_pkg::IDX_EP_CTL[0], 8'h88);
        hsk(ueh_pkg::TOK_IN, DEV, 0, 1'b1, ueh_pkg::HS_STALL); // in stalled
        hsk(ueh_pkg::TOK_OUT, DEV, 0, 1'b1, ueh_pkg::HS_NAK); // out keeps mode
        chk(ueh_pkg::IDX_STATUS, 8'h18, 1'b0); // both flags
        wr(ueh_pkg::IDX_EP_CTL[0], 8'h98);
        hsk(ueh_pkg::TOK_SETUP, DEV, 0, 1'b1, ueh_pkg::HS_ACK); // setup answered
        chk(ueh_pkg::IDX_EP_CTL[0], 8'h80, 1'b0); // overrides cleared
        wr(ueh_pkg::IDX_STATUS, 8'h00);
        chk(ueh_pkg::IDX_STATUS, 8'h00, 1'b0); // cleared by software
        $display("test stall done, mismatches %0d", err_total);
    endtask : t_stall
    task automatic t_ep0();
        wr(ueh_pkg::IDX_EP_CNT[0], 8'h82);
        wr(ueh_pkg::IDX_EP_CTL[0], 8'ha0);
        fill(2);
        drain(0, 2); // count sets the length
        chk(ueh_pkg::IDX_EP_CTL[0], 8'h80, 1'b0); // back to nak
        $display("test ep0 in done, mismatches %0d", err_total);
    endtask : t_ep0
    // full fifo holds the write off until the stream pops a slot
    task automatic t_fifo();
        time t0;
        wr(ueh_pkg::IDX_EP_CTL[1], 8'ha0);
        wr(ueh_pkg::IDX_EP_CNT[1], 8'h11);
        fill(16);
        ueh_host_model_i.slow = 1'b1;
        t0 = $time;
        fork
            begin
                wr(ueh_pkg::IDX_FIFO_DATA, 8'h50);
                cmp({31'h0, $time - t0 > 160}, 32'h1, "full fifo write");
            end
            begin
                repeat (6) @(posedge mclk);
                drain(1, 17); // count of seventeen streamed, one past the fifo depth
            end
        join
        ueh_host_model_i.slow = 1'b0;
        chk(ueh_pkg::IDX_EP_CTL[1], 8'h80, 1'b0); // in ack drops to nak
        chk(ueh_pkg::IDX_ACK_FLAGS, 8'h01, 1'b0); // ep1 flag
        $display("test fifo done, mismatches %0d", err_total);
    endtask : t_fifo
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        t_regs();
        t_modes();
        t_stall();
        t_ep0();
        t_fifo();
        close_out();
    end
    // watchdog, well past the tests' length
    initial begin
        repeat (20000) @(posedge mclk);
        cmp(32'h0, 32'h1, "watchdog");
        close_out();
    end
endmodule : testbench
